// ### verilog/iam_consts.svh
// constants of the ipv6 icmp entry matcher
`ifndef IAM_CONSTS_SVH
`define IAM_CONSTS_SVH

// next-header protocol numbers
`define IAM_PROTO_ICMPV6 8'h3a
`define IAM_PROTO_UDP 8'h11
`define IAM_PROTO_TCP 8'h06

// bit positions in the per-criterion result vector
`define IAM_CRIT_NH 0
`define IAM_CRIT_SRC 1
`define IAM_CRIT_HOP 2
`define IAM_CRIT_TYPE 3
`define IAM_CRIT_CODE 4
`define IAM_CRIT_COUNT 5

// reset values
`define IAM_RST_CRIT 5'h00
`define IAM_RST_COUNT 16'h0000

// pipeline depth from frame strobe to result
`define IAM_LATENCY 2

`endif

// ### verilog/iam_pkg.sv
// types of the ipv6 icmp entry matcher
package iam_pkg;

  typedef enum logic [2:0] {
    iam_nh_any,
    iam_nh_specific,
    iam_nh_icmp,
    iam_nh_udp,
    iam_nh_tcp
  } iam_nh_sel_e;

  typedef enum logic {
    iam_sel_any,
    iam_sel_specific
  } iam_sel_e;

  typedef enum logic [1:0] {
    iam_hop_any,
    iam_hop_zero,
    iam_hop_nonzero
  } iam_hop_sel_e;

endpackage

// ### verilog/iam_masked_cmp.sv
// registered masked equality compare of one header field
`timescale 1ns/1ps
module iam_masked_cmp #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // compare operands
  input wire logic care_in,
  input wire logic [WIDTH-1:0] field_in,
  input wire logic [WIDTH-1:0] value_in,
  input wire logic [WIDTH-1:0] mask_in,
  // result, one cycle after the operands
  output logic match_out
);

  logic [WIDTH-1:0] bit_ok;
  logic next_match;

  // a cleared mask bit makes that bit don't-care
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign bit_ok[i] = ~mask_in[i] | (field_in[i] ~^ value_in[i]);
  end

  always_comb begin
    next_match = ~care_in | (&bit_ok);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      match_out <= 1'b0;
    end else begin
      match_out <= next_match;
    end
  end

endmodule

// ### verilog/iam_hop_check.sv
// registered hop-limit condition of one entry
`timescale 1ns/1ps
module iam_hop_check
  import iam_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // condition and frame field
  input wire iam_hop_sel_e hop_sel_in,
  input wire logic [7:0] hop_limit_in,
  // result, one cycle after the inputs
  output logic hop_ok_out
);

  logic next_hop_ok;
  logic hop_positive;

  assign hop_positive = (hop_limit_in != 8'h00);

  always_comb begin
    next_hop_ok = 1'b0;
    unique case (hop_sel_in)
      iam_hop_any: begin
        next_hop_ok = 1'b1;
      end
      iam_hop_zero: begin
        next_hop_ok = ~hop_positive;
      end
      iam_hop_nonzero: begin
        next_hop_ok = hop_positive;
      end
      // unused code never hits
      default: begin
        next_hop_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hop_ok_out <= 1'b0;
    end else begin
      hop_ok_out <= next_hop_ok;
    end
  end

endmodule

// ### verilog/iam_matcher.sv
// match logic of one ipv6 access_control_entry with icmp parameters
`timescale 1ns/1ps
`include "iam_consts.svh"
module iam_matcher
  import iam_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // frame fields from the parser
  input wire logic frame_valid_in,
  input wire logic [7:0] next_header_in,
  input wire logic [31:0] source_low_address_in,
  input wire logic [7:0] hop_limit_in,
  input wire logic [7:0] l4_byte0_in,
  input wire logic [7:0] l4_byte1_in,
  // entry configuration
  input wire logic entry_enable_in,
  input wire iam_nh_sel_e nh_sel_in,
  input wire logic [7:0] nh_value_in,
  input wire iam_sel_e source_address_filter_in,
  input wire logic [31:0] source_low_address_value_in,
  input wire logic [31:0] source_low_address_mask_in,
  input wire iam_hop_sel_e hop_sel_in,
  input wire iam_sel_e icmp_type_sel_in,
  input wire logic [7:0] icmp_type_value_in,
  input wire iam_sel_e icmp_code_sel_in,
  input wire logic [7:0] icmp_code_value_in,
  // match result
  output logic result_valid_out,
  output logic hit_out,
  output logic [`IAM_CRIT_COUNT-1:0] criteria_out,
  output logic [COUNT_WIDTH-1:0] hit_count_out
);

  // stage one state
  logic s1_valid;
  logic s1_proto_ok;
  logic s1_enable;
  logic next_s1_valid;
  logic next_s1_proto_ok;
  logic next_s1_enable;

  // stage two state feeds the outputs directly
  logic next_result_valid;
  logic next_hit;
  logic [`IAM_CRIT_COUNT-1:0] next_criteria;
  logic [COUNT_WIDTH-1:0] next_hit_count;

  // stage one results of the compare units
  logic nh_value_ok;
  logic source_ok;
  logic hop_ok;
  logic type_ok;
  logic code_ok;

  logic nh_care;
  logic icmp_selected;
  logic type_care;
  logic code_care;
  logic [`IAM_CRIT_COUNT-1:0] s1_crit;

  assign nh_care = (nh_sel_in == iam_nh_specific);
  // type and code only count when the entry asks for icmp frames
  assign icmp_selected = (nh_sel_in == iam_nh_icmp);
  assign type_care = icmp_selected && (icmp_type_sel_in == iam_sel_specific);
  assign code_care = icmp_selected && (icmp_code_sel_in == iam_sel_specific);

  iam_masked_cmp #(
    .WIDTH(8)
  ) u_nh_cmp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .care_in(nh_care),
    .field_in(next_header_in),
    .value_in(nh_value_in),
    .mask_in(8'hff),
    .match_out(nh_value_ok)
  );

  // only the low word of the source address ever reaches this block
  iam_masked_cmp #(
    .WIDTH(32)
  ) u_source_cmp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .care_in(source_address_filter_in == iam_sel_specific),
    .field_in(source_low_address_in),
    .value_in(source_low_address_value_in),
    .mask_in(source_low_address_mask_in),
    .match_out(source_ok)
  );

  iam_hop_check u_hop (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .hop_sel_in(hop_sel_in),
    .hop_limit_in(hop_limit_in),
    .hop_ok_out(hop_ok)
  );

  iam_masked_cmp #(
    .WIDTH(8)
  ) u_type_cmp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .care_in(type_care),
    .field_in(l4_byte0_in),
    .value_in(icmp_type_value_in),
    .mask_in(8'hff),
    .match_out(type_ok)
  );

  iam_masked_cmp #(
    .WIDTH(8)
  ) u_code_cmp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .care_in(code_care),
    .field_in(l4_byte1_in),
    .value_in(icmp_code_value_in),
    .mask_in(8'hff),
    .match_out(code_ok)
  );

  // protocol restriction from the selector
  always_comb begin
    next_s1_valid = frame_valid_in;
    next_s1_enable = entry_enable_in;
    next_s1_proto_ok = 1'b0;
    unique case (nh_sel_in)
      iam_nh_any: begin
        next_s1_proto_ok = 1'b1;
      end
      iam_nh_specific: begin
        next_s1_proto_ok = 1'b1;
      end
      iam_nh_icmp: begin
        next_s1_proto_ok = (next_header_in == `IAM_PROTO_ICMPV6);
      end
      iam_nh_udp: begin
        next_s1_proto_ok = (next_header_in == `IAM_PROTO_UDP);
      end
      iam_nh_tcp: begin
        next_s1_proto_ok = (next_header_in == `IAM_PROTO_TCP);
      end
      // unused selector codes never hit
      default: begin
        next_s1_proto_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_valid <= 1'b0;
      s1_proto_ok <= 1'b0;
      s1_enable <= 1'b0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_proto_ok <= next_s1_proto_ok;
      s1_enable <= next_s1_enable;
    end
  end

  always_comb begin
    s1_crit = `IAM_RST_CRIT;
    s1_crit[`IAM_CRIT_NH] = s1_proto_ok & nh_value_ok;
    s1_crit[`IAM_CRIT_SRC] = source_ok;
    s1_crit[`IAM_CRIT_HOP] = hop_ok;
    s1_crit[`IAM_CRIT_TYPE] = type_ok;
    s1_crit[`IAM_CRIT_CODE] = code_ok;
  end

  // results hold between frames; valid marks the fresh one
  always_comb begin
    next_result_valid = s1_valid;
    next_criteria = criteria_out;
    next_hit = hit_out;
    next_hit_count = hit_count_out;
    if (s1_valid) begin
      next_criteria = s1_crit;
      next_hit = s1_enable & (&s1_crit);
      if (s1_enable && (&s1_crit)) begin
        // wraps silently; software samples differences
        next_hit_count = hit_count_out + COUNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_valid_out <= 1'b0;
      hit_out <= 1'b0;
      criteria_out <= `IAM_RST_CRIT;
      hit_count_out <= COUNT_WIDTH'(0);
    end else begin
      result_valid_out <= next_result_valid;
      hit_out <= next_hit;
      criteria_out <= next_criteria;
      hit_count_out <= next_hit_count;
    end
  end

  nh_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_any) |-> criteria_out[`IAM_CRIT_NH])
    else $error("next header any did not hit");

  nh_specific_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_specific)
    |-> criteria_out[`IAM_CRIT_NH] == ($past(next_header_in, 2) == $past(nh_value_in, 2)))
    else $error("next header value compare wrong");

  nh_proto_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_icmp)
    |-> criteria_out[`IAM_CRIT_NH] == ($past(next_header_in, 2) == `IAM_PROTO_ICMPV6))
    else $error("icmp protocol restriction wrong");

  source_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(source_address_filter_in, 2) == iam_sel_any)
    |-> criteria_out[`IAM_CRIT_SRC])
    else $error("source any did not hit");

  source_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(source_address_filter_in, 2) == iam_sel_specific)
    |-> criteria_out[`IAM_CRIT_SRC] == ((($past(source_low_address_in, 2)
    ^ $past(source_low_address_value_in, 2)) & $past(source_low_address_mask_in, 2)) == 32'h0000_0000))
    else $error("masked source compare wrong");

  hop_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(hop_sel_in, 2) == iam_hop_zero && $past(hop_limit_in, 2) != 8'h00)
    |-> !hit_out)
    else $error("hop zero condition let a frame hit");

  hop_nonzero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(hop_sel_in, 2) == iam_hop_nonzero)
    |-> criteria_out[`IAM_CRIT_HOP] == ($past(hop_limit_in, 2) != 8'h00))
    else $error("hop non-zero condition wrong");

  icmp_type_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_icmp && $past(icmp_type_sel_in, 2) == iam_sel_specific)
    |-> criteria_out[`IAM_CRIT_TYPE] == ($past(l4_byte0_in, 2) == $past(icmp_type_value_in, 2)))
    else $error("icmp type compare wrong");

  icmp_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_icmp && $past(icmp_code_sel_in, 2) == iam_sel_specific)
    |-> criteria_out[`IAM_CRIT_CODE] == ($past(l4_byte1_in, 2) == $past(icmp_code_value_in, 2)))
    else $error("icmp code compare wrong");

  non_icmp_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) != iam_nh_icmp)
    |-> criteria_out[`IAM_CRIT_TYPE] && criteria_out[`IAM_CRIT_CODE])
    else $error("icmp fields judged on a non-icmp entry");

  all_hit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    result_valid_out |-> hit_out == ($past(entry_enable_in, 2) && (&criteria_out)))
    else $error("hit does not combine all criteria");

  // the counter steps at the same edge that raises the result
  count_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && hit_out) |-> hit_count_out == $past(hit_count_out) + COUNT_WIDTH'(1))
    else $error("hit counter did not advance");

  count_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(result_valid_out && hit_out) |-> hit_count_out == $past(hit_count_out))
    else $error("hit counter moved without a hit");

  nh_udp_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_udp)
    |-> criteria_out[`IAM_CRIT_NH] == ($past(next_header_in, 2) == `IAM_PROTO_UDP))
    else $error("udp protocol restriction wrong");

  nh_tcp_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(nh_sel_in, 2) == iam_nh_tcp)
    |-> criteria_out[`IAM_CRIT_NH] == ($past(next_header_in, 2) == `IAM_PROTO_TCP))
    else $error("tcp protocol restriction wrong");

  hop_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(hop_sel_in, 2) == iam_hop_any) |-> criteria_out[`IAM_CRIT_HOP])
    else $error("hop any did not pass");

  type_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(icmp_type_sel_in, 2) == iam_sel_any) |-> criteria_out[`IAM_CRIT_TYPE])
    else $error("icmp type any did not pass");

  code_any_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (result_valid_out && $past(icmp_code_sel_in, 2) == iam_sel_any) |-> criteria_out[`IAM_CRIT_CODE])
    else $error("icmp code any did not pass");

endmodule

// ### verif/iam_parser_model.sv
// frame parser model feeding extracted ipv6 header fields to the entry matcher
`timescale 1ns/1ps
module iam_parser_model (
  // clock
  input wire logic clk_in,
  // extracted fields
  output logic frame_valid_out,
  output logic [7:0] next_header_out,
  output logic [31:0] source_low_address_out,
  output logic [7:0] hop_limit_out,
  output logic [7:0] l4_byte0_out,
  output logic [7:0] l4_byte1_out
);
  initial begin
    frame_valid_out = 1'b0;
    next_header_out = 8'h00;
    source_low_address_out = 32'h0000_0000;
    hop_limit_out = 8'h00;
    l4_byte0_out = 8'h00;
    l4_byte1_out = 8'h00;
  end

  task automatic send(input logic [7:0] nh, input logic [31:0] src, input logic [7:0] hop,
    input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk_in);
    frame_valid_out <= 1'b1;
    next_header_out <= nh;
    source_low_address_out <= src;
    hop_limit_out <= hop;
    l4_byte0_out <= b0;
    l4_byte1_out <= b1;
    @(posedge clk_in);
    // fields outside the strobe are garbage: inverted so stale values cannot pass
    frame_valid_out <= 1'b0;
    next_header_out <= ~nh;
    source_low_address_out <= ~src;
    hop_limit_out <= ~hop;
    l4_byte0_out <= ~b0;
    l4_byte1_out <= ~b1;
  endtask
endmodule

// ### verif/testbench.sv
// self-checking bench of the ipv6 icmp entry matcher
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
      error_cnt++; \
    end \
  end
module testbench
  import iam_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic fv;
  logic [7:0] nh;
  logic [31:0] src;
  logic [7:0] hop;
  logic [7:0] b0;
  logic [7:0] b1;
  logic en = 1'b1;
  iam_nh_sel_e nhs = iam_nh_any;
  logic [7:0] nhv = 8'h00;
  iam_sel_e ss = iam_sel_any;
  logic [31:0] sv = 32'h0000_0000;
  logic [31:0] sm = 32'h0000_0000;
  iam_hop_sel_e hs = iam_hop_any;
  iam_sel_e ts = iam_sel_any;
  logic [7:0] tv = 8'h00;
  iam_sel_e cs = iam_sel_any;
  logic [7:0] cv = 8'h00;
  logic result_valid_out;
  logic hit_out;
  logic [4:0] criteria_out;
  logic [15:0] hit_count_out;
  logic [15:0] exp_cnt = 16'h0000;
  int error_cnt = 0;
  int cmp_count = 0;

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  iam_parser_model parser_u (.clk_in(clk_in), .frame_valid_out(fv), .next_header_out(nh),
    .source_low_address_out(src), .hop_limit_out(hop), .l4_byte0_out(b0), .l4_byte1_out(b1));

  iam_matcher #(.COUNT_WIDTH(16)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .frame_valid_in(fv),
    .next_header_in(nh), .source_low_address_in(src), .hop_limit_in(hop), .l4_byte0_in(b0),
    .l4_byte1_in(b1), .entry_enable_in(en), .nh_sel_in(nhs), .nh_value_in(nhv),
    .source_address_filter_in(ss), .source_low_address_value_in(sv), .source_low_address_mask_in(sm),
    .hop_sel_in(hs), .icmp_type_sel_in(ts), .icmp_type_value_in(tv), .icmp_code_sel_in(cs),
    .icmp_code_value_in(cv), .result_valid_out(result_valid_out), .hit_out(hit_out),
    .criteria_out(criteria_out), .hit_count_out(hit_count_out));

  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cfg(input logic e, input iam_nh_sel_e a, input logic [7:0] av, input iam_sel_e s,
    input logic [31:0] v, input logic [31:0] m, input iam_hop_sel_e h, input iam_sel_e t,
    input logic [7:0] tvv, input iam_sel_e c, input logic [7:0] cvv);
    @(posedge clk_in);
    en <= e;
    nhs <= a;
    nhv <= av;
    ss <= s;
    sv <= v;
    sm <= m;
    hs <= h;
    ts <= t;
    tv <= tvv;
    cs <= c;
    cv <= cvv;
  endtask

  // one frame; the result rises one edge after the edge that takes it
  task automatic frame(input logic [7:0] n, input logic [31:0] s, input logic [7:0] h, input logic [7:0] x,
    input logic [7:0] y, input logic eh, input logic [4:0] ec);
    int k;
    k = 0;
    parser_u.send(n, s, h, x, y);
    while (result_valid_out !== 1'b1 && k < 6) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k >= 6) begin
      error_cnt++;
      end_sim();
    end
    if (eh) exp_cnt++;
    `CHK(k, 1)
    `CHK(hit_out, eh)
    `CHK(criteria_out, ec)
    `CHK(hit_count_out, exp_cnt)
  endtask

  task automatic t_nh();
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h11, 32'h1234_5678, 8'h40, 8'h00, 8'h00, 1'b1, 5'h1f);
    cfg(1'b1, iam_nh_specific, 8'h2b, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h2b, 32'h0000_0000, 8'h40, 8'h00, 8'h00, 1'b1, 5'h1f);
    frame(8'h2a, 32'h0000_0000, 8'h40, 8'h00, 8'h00, 1'b0, 5'h1e);
    cfg(1'b0, iam_nh_specific, 8'h2b, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h2b, 32'h0000_0000, 8'h40, 8'h00, 8'h00, 1'b0, 5'h1f);
    // reserved selector code must never hit
    cfg(1'b1, iam_nh_sel_e'(3'd5), 8'h2b, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00,
      iam_sel_any, 8'h00);
    frame(8'h2b, 32'h0000_0000, 8'h40, 8'h00, 8'h00, 1'b0, 5'h1e);
  endtask

  task automatic t_proto();
    iam_nh_sel_e sel [3];
    logic [7:0] pr [3];
    sel = '{iam_nh_icmp, iam_nh_udp, iam_nh_tcp};
    pr = '{8'h3a, 8'h11, 8'h06};
    for (int i = 0; i < 3; i++) begin
      cfg(1'b1, sel[i], 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
      frame(pr[i], 32'h0000_0000, 8'h01, 8'h00, 8'h00, 1'b1, 5'h1f);
      frame(pr[(i + 1) % 3], 32'h0000_0000, 8'h01, 8'h00, 8'h00, 1'b0, 5'h1e);
    end
  endtask

  task automatic t_src();
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_specific, 32'h0000_0003, 32'hffff_fffe, iam_hop_any, iam_sel_any, 8'h00,
      iam_sel_any, 8'h00);
    frame(8'h11, 32'h0000_0002, 8'h01, 8'h00, 8'h00, 1'b1, 5'h1f);
    frame(8'h11, 32'h0000_0003, 8'h01, 8'h00, 8'h00, 1'b1, 5'h1f);
    frame(8'h11, 32'h0000_0001, 8'h01, 8'h00, 8'h00, 1'b0, 5'h1d);
    frame(8'h11, 32'h8000_0003, 8'h01, 8'h00, 8'h00, 1'b0, 5'h1d);
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0000_0003, 32'hffff_fffe, iam_hop_any, iam_sel_any, 8'h00,
      iam_sel_any, 8'h00);
    frame(8'h11, 32'h0000_0001, 8'h01, 8'h00, 8'h00, 1'b1, 5'h1f);
  endtask

  task automatic t_hop();
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_zero, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h06, 32'h0, 8'h01, 8'h00, 8'h00, 1'b0, 5'h1b);
    frame(8'h06, 32'h0, 8'h00, 8'h00, 8'h00, 1'b1, 5'h1f);
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_nonzero, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h06, 32'h0, 8'hff, 8'h00, 8'h00, 1'b1, 5'h1f);
    frame(8'h06, 32'h0, 8'h00, 8'h00, 8'h00, 1'b0, 5'h1b);
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h00, iam_sel_any, 8'h00);
    frame(8'h06, 32'h0, 8'h00, 8'h00, 8'h00, 1'b1, 5'h1f);
    frame(8'h06, 32'h0, 8'h80, 8'h00, 8'h00, 1'b1, 5'h1f);
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_sel_e'(2'd3), iam_sel_any, 8'h00,
      iam_sel_any, 8'h00);
    frame(8'h06, 32'h0, 8'h01, 8'h00, 8'h00, 1'b0, 5'h1b);
  endtask

  task automatic t_icmp();
    cfg(1'b1, iam_nh_icmp, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_specific, 8'h80,
      iam_sel_specific, 8'h00);
    frame(8'h3a, 32'h0, 8'h01, 8'h80, 8'h00, 1'b1, 5'h1f);
    frame(8'h3a, 32'h0, 8'h01, 8'h81, 8'h00, 1'b0, 5'h17);
    frame(8'h3a, 32'h0, 8'h01, 8'h80, 8'h01, 1'b0, 5'h0f);
    frame(8'h3a, 32'h0, 8'h01, 8'h80, 8'hff, 1'b0, 5'h0f);
    cfg(1'b1, iam_nh_icmp, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_any, 8'h80, iam_sel_any, 8'h00);
    frame(8'h3a, 32'h0, 8'h01, 8'hff, 8'hff, 1'b1, 5'h1f);
    cfg(1'b1, iam_nh_any, 8'h00, iam_sel_any, 32'h0, 32'h0, iam_hop_any, iam_sel_specific, 8'h80,
      iam_sel_specific, 8'h00);
    frame(8'h3a, 32'h0, 8'h01, 8'h01, 8'h01, 1'b1, 5'h1f);
  endtask

  // reset in mid-run clears the result and the hit counter
  task automatic t_reset();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK({result_valid_out, hit_out, criteria_out, hit_count_out}, 23'h00_0000)
    exp_cnt = 16'h0000;
    @(posedge clk_in);
    rst_in <= 1'b0;
    frame(8'h3a, 32'h0, 8'h01, 8'h80, 8'h00, 1'b1, 5'h1f);
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    `CHK({result_valid_out, hit_out, criteria_out, hit_count_out}, 23'h00_0000)
    t_nh();
    t_proto();
    t_src();
    t_hop();
    t_icmp();
    t_reset();
    end_sim();
  end
endmodule
